// ===== verilog/codec_power_bias_regs.v
// Purpose: Power gating and headphone bias control registers of the codec core
// Assumes: One clock; register port strobes synchronous to clk
// Notes: Clock gates are latch-free AND gates fed from register flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "codec_power_bias_defines.vh"

module codec_power_bias_regs (
  input wire clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire reg_hit,
  input wire [3:0] filter_clk_in,
  input wire [3:0] down_conv_clk_in,
  output wire [3:0] filter_clk_out,
  output wire [3:0] down_conv_clk_out,
  output wire [3:0] conv_filter_power_bits,
  output wire [3:0] rate_conv_down_power,
  output wire output_modulator0_power,
  output wire output_modulator1_power,
  output wire rate_conv_up0_power,
  output wire rate_conv_up1_power,
  output wire [1:0] phones_bias_mode,
  output reg phones_bias_normal,
  output reg phones_bias_extreme_save,
  output reg phones_bias_enhanced,
  output reg phones_bias_save
);

  reg [7:0] input_filter_power_gate;
  reg [7:0] output_path_power_gate;
  reg [7:0] analog_bias_select_a;
  reg [7:0] next_input_filter_power_gate;
  reg [7:0] next_output_path_power_gate;
  reg [7:0] next_analog_bias_select_a;
  reg [7:0] next_rdata;
  wire sel_input_gate;
  wire sel_output_gate;
  wire sel_bias;
  wire wr_input_gate;
  wire wr_output_gate;
  wire wr_bias;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // register offsets
  assign sel_input_gate = (reg_addr == `INPUT_FILTER_POWER_GATE_ADDR);
  assign sel_output_gate = (reg_addr == `OUTPUT_PATH_POWER_GATE_ADDR);
  assign sel_bias = (reg_addr == `ANALOG_BIAS_SELECT_A_ADDR);

  // Unmapped addresses keep reg_hit low and read as zero, so banks can be OR-ed
  assign reg_hit = sel_input_gate | sel_output_gate | sel_bias;

  assign wr_input_gate = reg_wr & sel_input_gate;
  assign wr_output_gate = reg_wr & sel_output_gate;
  assign wr_bias = reg_wr & sel_bias;

  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  // reserved bits stored
  always @* begin
    next_input_filter_power_gate = input_filter_power_gate;
    if (wr_input_gate) begin
      next_input_filter_power_gate = reg_wdata;
    end
  end

  always @* begin
    next_output_path_power_gate = output_path_power_gate;
    if (wr_output_gate) begin
      next_output_path_power_gate = reg_wdata;
    end
  end

  always @* begin
    next_analog_bias_select_a = analog_bias_select_a;
    if (wr_bias) begin
      next_analog_bias_select_a = reg_wdata;
    end
  end

  // ----------------------------------------
  // Register flops
  // ----------------------------------------
  // reset values
  // Synchronous reset: every gate closes on the first edge seen with rst_b low
  always @(posedge clk) begin
    if (!rst_b) begin
      input_filter_power_gate <= `INPUT_FILTER_POWER_GATE_RST;
    end else begin
      input_filter_power_gate <= next_input_filter_power_gate;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      output_path_power_gate <= `OUTPUT_PATH_POWER_GATE_RST;
    end else begin
      output_path_power_gate <= next_output_path_power_gate;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      analog_bias_select_a <= `ANALOG_BIAS_SELECT_A_RST;
    end else begin
      analog_bias_select_a <= next_analog_bias_select_a;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    case (reg_addr)
      `INPUT_FILTER_POWER_GATE_ADDR: begin
        next_rdata = input_filter_power_gate;
      end
      `OUTPUT_PATH_POWER_GATE_ADDR: begin
        next_rdata = output_path_power_gate;
      end
      `ANALOG_BIAS_SELECT_A_ADDR: begin
        next_rdata = analog_bias_select_a;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // reserved bits returned
  // A read that meets a write in one cycle returns the old value
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Input path power and clock gating
  // ----------------------------------------
  // Power enables come straight from flops, so they never glitch
  // down-rate converter bits
  assign rate_conv_down_power = input_filter_power_gate[`RATE_CONV_DOWN_LSB +: 4];
  assign conv_filter_power_bits = input_filter_power_gate[`CONV_FILTER_LSB +: 4];

  // Enables only change on clk, not on the gated clocks; a glitch-free
  // gate needs the enable retimed in each gated domain by the integrator
  genvar ch;
  generate
    for (ch = 0; ch < `INPUT_CHANNELS; ch = ch + 1) begin : g_gate
      assign filter_clk_out[ch] = filter_clk_in[ch] & conv_filter_power_bits[ch];
      assign down_conv_clk_out[ch] = down_conv_clk_in[ch] & rate_conv_down_power[ch];
    end
  endgenerate

  // ----------------------------------------
  // Output path power
  // ----------------------------------------
  // Bits 7..4 are stored only and drive nothing
  // modulator enables
  assign output_modulator1_power = output_path_power_gate[`OUTPUT_MODULATOR1_BIT];
  assign output_modulator0_power = output_path_power_gate[`OUTPUT_MODULATOR0_BIT];
  assign rate_conv_up1_power = output_path_power_gate[`RATE_CONV_UP1_BIT];
  assign rate_conv_up0_power = output_path_power_gate[`RATE_CONV_UP0_BIT];

  // ----------------------------------------
  // Headphone bias
  // ----------------------------------------
  // Bits 5..0 of the bias register are stored only
  // bias field
  assign phones_bias_mode = analog_bias_select_a[`PHONES_BIAS_MSB:`PHONES_BIAS_LSB];

  always @* begin
    phones_bias_normal = 1'h0;
    phones_bias_extreme_save = 1'h0;
    phones_bias_enhanced = 1'h0;
    phones_bias_save = 1'h0;
    case (phones_bias_mode)
      `PHONES_BIAS_NORMAL: begin
        phones_bias_normal = 1'h1;
      end
      `PHONES_BIAS_EXTREME_SAVE: begin
        phones_bias_extreme_save = 1'h1;
      end
      `PHONES_BIAS_ENHANCED: begin
        phones_bias_enhanced = 1'h1;
      end
      `PHONES_BIAS_SAVE: begin
        phones_bias_save = 1'h1;
      end
      default: begin
        phones_bias_normal = 1'h1;
      end
    endcase
  end

endmodule // codec_power_bias_regs
`default_nettype wire

// ===== verilog/codec_power_bias_defines.vh
// Purpose: Offsets, field positions and reset values of the power and bias registers
// Assumes: Byte-wide register port with byte addresses
// Notes: Definitions only
`ifndef CODEC_POWER_BIAS_DEFINES_VH
`define CODEC_POWER_BIAS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define INPUT_FILTER_POWER_GATE_ADDR 8'h44
`define OUTPUT_PATH_POWER_GATE_ADDR 8'h45
`define ANALOG_BIAS_SELECT_A_ADDR 8'h46

// ----------------------------------------
// Reset values
// ----------------------------------------
`define INPUT_FILTER_POWER_GATE_RST 8'h00
`define OUTPUT_PATH_POWER_GATE_RST 8'h00
`define ANALOG_BIAS_SELECT_A_RST 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RATE_CONV_DOWN_LSB 4
`define CONV_FILTER_LSB 0
`define OUTPUT_MODULATOR0_BIT 2
`define OUTPUT_MODULATOR1_BIT 3
`define RATE_CONV_UP0_BIT 0
`define RATE_CONV_UP1_BIT 1
`define PHONES_BIAS_MSB 7
`define PHONES_BIAS_LSB 6

// ----------------------------------------
// Headphone bias mode codes
// ----------------------------------------
`define PHONES_BIAS_NORMAL 2'h0
`define PHONES_BIAS_EXTREME_SAVE 2'h1
`define PHONES_BIAS_ENHANCED 2'h2
`define PHONES_BIAS_SAVE 2'h3

// Number of gated input channels
`define INPUT_CHANNELS 4

`endif

// ===== tb/pwr_bias_checker.sv
// Purpose: Port assertions for the power and bias registers
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound to the register block by name
`timescale 1ns/1ps
`default_nettype none
module pwr_bias_checker (
  input wire logic clk, rst_b, reg_wr, reg_rd, reg_hit,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [3:0] filter_clk_in, filter_clk_out, conv_filter_power_bits,
  input wire logic [3:0] down_conv_clk_in, down_conv_clk_out, rate_conv_down_power,
  input wire logic output_modulator0_power, output_modulator1_power,
  input wire logic rate_conv_up0_power, rate_conv_up1_power, phones_bias_normal,
  input wire logic phones_bias_extreme_save, phones_bias_enhanced, phones_bias_save,
  input wire logic [1:0] phones_bias_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire [7:0] r44 = {rate_conv_down_power, conv_filter_power_bits};
  wire [3:0] r45 = {output_modulator1_power, output_modulator0_power, rate_conv_up1_power,
    rate_conv_up0_power};
  wire [3:0] dec = {phones_bias_save, phones_bias_enhanced, phones_bias_extreme_save,
    phones_bias_normal};
  in_gate_wr_a: assert property (
    reg_wr && reg_addr == 8'h44 |=> r44 == $past(reg_wdata))
    else $error("in gate");
  out_gate_wr_a: assert property (
    reg_wr && reg_addr == 8'h45 |=> r45 == $past(reg_wdata[3:0]))
    else $error("out gate");
  bias_wr_a: assert property (
    reg_wr && reg_addr == 8'h46 |=> phones_bias_mode == $past(reg_wdata[7:6]))
    else $error("bias wr");
  bias_decode_a: assert property (
    dec == 4'h1 << phones_bias_mode)
    else $error("decode");
  clk_gate_a: assert property (
    filter_clk_out == (filter_clk_in & conv_filter_power_bits))
    else $error("gate");
  down_gate_a: assert property (
    down_conv_clk_out == (down_conv_clk_in & rate_conv_down_power))
    else $error("down gate");
  read_back_a: assert property (
    reg_rd && reg_addr == 8'h44 |=> reg_rdata == $past(r44))
    else $error("read");
  addr_map_a: assert property (
    reg_hit == (reg_addr inside {8'h44, 8'h45, 8'h46}))
    else $error("hit");
  reset_clear_a: assert property (
    disable iff (1'b0) !rst_b |=> r44 == 8'h00 && r45 == 4'h0 && dec == 4'h1)
    else $error("reset");
  cover property (reg_wr && reg_addr == 8'h46);
  cover property (reg_rd && !reg_hit);
  cover property (reg_rd && reg_wr && reg_hit);
endmodule // pwr_bias_checker
bind codec_power_bias_regs pwr_bias_checker u_chk (.*);
`default_nettype wire

// ===== tb/host_ctl.sv
// Purpose: Host software model driving the register port
// Assumes: Strobes change at falling edges only
// Notes: Data lines are inverted once the strobe drops
`timescale 1ns/1ps
`default_nettype none
module host_ctl (
  input wire logic clk,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_wdata,
  output var logic reg_wr,
  output var logic reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
  task acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, r};
    @(negedge clk);
    {reg_wdata, reg_wr, reg_rd} = {~d, 2'b00};
  endtask
endmodule // host_ctl
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the power and bias registers
// Assumes: Host model owns the register port
// Notes: Register array model gives expected register and output values; reg_hit and unmapped reads are checked against constants
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: mismatch", $time); end end
module tb_top;
  logic clk = 0, rst_b = 0;
  logic [3:0] filter_clk_in = 0, down_conv_clk_in = 0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_hit, output_modulator0_power, output_modulator1_power;
  wire [3:0] filter_clk_out, down_conv_clk_out, conv_filter_power_bits, rate_conv_down_power;
  wire rate_conv_up0_power, rate_conv_up1_power, phones_bias_normal, phones_bias_extreme_save;
  wire phones_bias_enhanced, phones_bias_save;
  wire [1:0] phones_bias_mode;
  wire [3:0] out_pwr = {output_modulator1_power, output_modulator0_power, rate_conv_up1_power,
    rate_conv_up0_power};
  wire [3:0] bias_dec = {phones_bias_save, phones_bias_enhanced, phones_bias_extreme_save,
    phones_bias_normal};
  int failures = 0, n_tests = 0;
  logic [31:0] s = 18, r;
  logic [7:0] m[3] = '{default: 0};
  codec_power_bias_regs u_dut (.*);
  host_ctl h (.*);
  always #5 clk = ~clk;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk_all;
    {filter_clk_in, down_conv_clk_in} = 8'(xs());
    #1;
    `CHK({rate_conv_down_power, conv_filter_power_bits}, m[0])
    `CHK(out_pwr, m[1][3:0])
    `CHK(phones_bias_mode, m[2][7:6])
    `CHK(bias_dec, 4'h1 << m[2][7:6])
    `CHK({down_conv_clk_out, filter_clk_out}, {down_conv_clk_in, filter_clk_in} & m[0])
  endtask
  task rd(input int i);
    h.acc(8'(8'h44 + i), 8'h00, 0, 1);
    `CHK(reg_rdata, m[i])
    `CHK(reg_hit, 1'b1)
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    for (int i = 0; i < 3; i++) rd(i);
    $display("reset test done");
    for (int k = 0; k < 40; k++) begin
      r = xs();
      h.acc(8'(8'h44 + r[9:8]), r[7:0], 1, r[9:8] == 3);
      if (r[9:8] == 3) begin
        `CHK(reg_rdata, 8'h00)
        `CHK(reg_hit, 1'b0)
      end else m[r[9:8]] = r[7:0];
      chk_all;
      if (r[9:8] != 3) rd(r[9:8]);
    end
    for (int b = 0; b < 4; b++) begin
      h.acc(8'h46, {b[1:0], 6'h2a}, 1, 1);
      `CHK(reg_rdata, m[2])
      m[2] = {b[1:0], 6'h2a};
      chk_all;
    end
    $display("random and bias test done");
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    m = '{default: 0};
    `CHK(reg_rdata, 8'h00)
    chk_all;
    for (int i = 0; i < 3; i++) rd(i);
    $display("mid reset test done");
    end_of_test;
  end
  initial begin
    #100us;
    failures++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
